// *** buck_seq_pkg.sv ***
// buck_seq_pkg: register map, field positions, reset values and timing constants
// assumes a 100 MHz system clock and a 300 kHz switching cycle made from it
package buck_seq_pkg;
   // register byte offsets
   localparam logic [7:0] ctrl_addr = 8'h00;
   localparam logic [7:0] status_addr = 8'h04;
   localparam logic [7:0] ramp_addr = 8'h08;
   localparam logic [7:0] ocset_addr = 8'h0c;
   localparam logic [7:0] count_addr = 8'h10;
   // control fields
   localparam int ctrl_soft_dis_bit = 0;
   localparam int ctrl_fixed_oc_bit = 1;
   localparam logic [31:0] ctrl_reset = 32'h0000_0000;
   localparam logic [31:0] bad_addr_data = 32'h0000_0000;
   // timing
   localparam int clk_hz = 100_000_000;
   localparam int sw_hz = 300_000;
   localparam int sw_div = clk_hz / sw_hz;
   localparam int hiccup_cycles = 2048;
   localparam int ss_cycles = 1530;
   localparam int ocset_min_us = 5500;
   localparam int ocset_min_cycles = (ocset_min_us * (sw_hz / 1000)) / 1000;
   localparam int ocset_span_cycles = 300;
   localparam int ref_bits = 12;
   localparam int oc_bits = 8;
   localparam int watchdog_cycles = 50;
   localparam logic [ref_bits-1:0] ref_full = 12'hfff;
   localparam logic [oc_bits-1:0] oc_fixed_code = 8'h80;
   // sequencer states
   typedef enum logic [2:0] {
      st_lockout, st_ocset, st_soft, st_run, st_off, st_disabled
   } seq_state_t;
   // switch phase within one cycle
   typedef enum logic [1:0] {
      ph_idle, ph_high, ph_dead_lo, ph_low
   } drv_phase_t;
endpackage : buck_seq_pkg

// *** pin_sync3.sv ***
// pin_sync3: three-stage synchroniser for one asynchronous comparator level
// assumes the level is quasi-static relative to clk_sys
`timescale 1ns/1ps
module pin_sync3 (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // level in and out
   input wire logic din,
   output logic dout
);
   logic s1;
   logic s2;
   logic s3;
   // the first stage feeds only the second; change counts once stages two and three agree
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         dout <= 1'b0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            dout <= s3;
         end
      end
   end
endmodule : pin_sync3

// *** gate_driver_phase.sv ***
// gate_driver_phase: adaptive dead-time for one switching leg
// assumes pwm_on is clk_sys-synchronous and sense inputs are already synchronised
`timescale 1ns/1ps
module gate_driver_phase #(
   parameter int wd_cycles = buck_seq_pkg::watchdog_cycles
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // control
   input wire logic pwm_on,
   input wire logic low_allowed,
   input wire logic force_low,
   input wire logic all_off,
   // sensing
   input wire logic phase_low,
   input wire logic low_gate_low,
   // drive
   output logic high_en,
   output logic low_en,
   output logic watchdog_fire
);
   buck_seq_pkg::drv_phase_t ph;
   buck_seq_pkg::drv_phase_t next_ph;
   logic [7:0] wd_cnt;
   wire wd_done = (wd_cnt == 8'(wd_cycles));
   // low-side only after the node has fallen, or when the watchdog gives up waiting
   wire low_ok = phase_low || wd_done; // RL9 RL11
   always_comb begin
      next_ph = ph;
      unique case (ph)
         buck_seq_pkg::ph_idle: if (pwm_on && low_gate_low) next_ph = buck_seq_pkg::ph_high; // RL10
            else if (!pwm_on && low_allowed) next_ph = buck_seq_pkg::ph_dead_lo; // RL7
         buck_seq_pkg::ph_high: if (!pwm_on) next_ph = buck_seq_pkg::ph_dead_lo;
         buck_seq_pkg::ph_dead_lo: if (low_ok) next_ph = buck_seq_pkg::ph_low;
         buck_seq_pkg::ph_low: if (pwm_on) next_ph = buck_seq_pkg::ph_idle;
      endcase
      if (all_off || force_low) next_ph = buck_seq_pkg::ph_idle;
   end
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ph <= buck_seq_pkg::ph_idle;
         wd_cnt <= 8'h00;
         high_en <= 1'b0;
         low_en <= 1'b0;
         watchdog_fire <= 1'b0;
      end else begin
         ph <= next_ph;
         wd_cnt <= (ph == buck_seq_pkg::ph_dead_lo && !wd_done) ? wd_cnt + 8'h01 : 8'h00;
         high_en <= (next_ph == buck_seq_pkg::ph_high) && !force_low;
         // protections pass the startup inhibit, the loop does not
         low_en <= !all_off && (force_low || (next_ph == buck_seq_pkg::ph_low && low_allowed)); // RL8
         watchdog_fire <= (ph == buck_seq_pkg::ph_dead_lo) && wd_done && !phase_low; // RL11
      end
   end
   chk_high_needs_gate: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL10
      $rose(high_en) |-> $past(low_gate_low) || $past(ph) == buck_seq_pkg::ph_high)
      else $error("high side on before low gate fell");
   chk_no_overlap: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL9
      !(high_en && low_en))
      else $error("both switches on");
endmodule : gate_driver_phase

// *** buck_startup_protection_sequencer.sv ***
// buck_startup_protection_sequencer: startup, protection and gate sequencing of a buck leg
// assumes comparator levels arrive asynchronously; apb runs on clk_sys
// Function
// RL1: ramp reference zero to full in 5.1 ms
// RL2: switching cycle fixed at 300 kHz
// RL3: overcurrent in soft-start: residual plus 2048 off
// RL4: soft-start needs supply ok and programming done
// RL5: low side inhibited until high side switches
// RL6: pre-bias below: both off until ramp passes
// RL7: pre-bias above: low side enabled at ramp end
// RL8: protections force low side despite inhibit
// RL9: low side waits for switch node low
// RL10: high side waits for low gate low
// RL11: watchdog turns low side on anyway
// RL12: disable pin low: both off, source current
// RL13: pin release: full new soft-start
// RL14: external pull-down must overpower pin current
// RL15: compare low-side drop to stored threshold
// RL16: two consecutive events: 2048 cycles off
// RL17: persistent fault gives hiccup restart loop
// RL18: overcurrent trip set by external resistor
// RL19: after soft-start undervoltage: off 2048 cycles
// RL20: overvoltage forces low side, top priority
// RL21: threshold programming 5.5 to 6.5 ms
// RL22: comparator levels synchronised before use
// RL23: ramp is a digital code stepping per cycle
`timescale 1ns/1ps
module buck_startup_protection_sequencer #(
   parameter int ss_len = buck_seq_pkg::ss_cycles,
   parameter int off_len = buck_seq_pkg::hiccup_cycles,
   parameter int ocset_len = buck_seq_pkg::ocset_min_cycles
) (
   // clock and reset (reset held by supply lockout)
   input wire logic clk_sys,
   input wire logic sys_rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // comparator levels, asynchronous
   input wire logic supply_lockout_ok,
   input wire logic phase_below_th,
   input wire logic low_gate_below_th,
   input wire logic oc_drop_over_th,
   input wire logic feedback_input_under,
   input wire logic feedback_input_over,
   input wire logic feedback_input_below_ref,
   input wire logic error_amp_output_disable_pin_low,
   input wire logic pwm_cmp,
   // programming sample from the external resistor
   input wire logic [7:0] ocset_sample,
   // outputs
   output logic high_side_switch,
   output logic low_side_switch,
   output logic disable_source_on,
   output logic ocset_sink_on,
   output logic [11:0] ref_code,
   output logic [7:0] oc_threshold
);
   // synchronised levels
   logic sup_ok;
   logic ph_low;
   logic lg_low;
   logic oc_raw;
   logic fb_uv;
   logic fb_ov;
   logic fb_below;
   logic dis_low;
   logic pwm_s;
   logic [8:0] sync_out;
   wire [8:0] sync_in = {supply_lockout_ok, phase_below_th, low_gate_below_th, oc_drop_over_th,
      feedback_input_under, feedback_input_over, feedback_input_below_ref,
      error_amp_output_disable_pin_low, pwm_cmp};
   genvar gi;
   generate
      for (gi = 0; gi < 9; gi++) begin : g_sync
         pin_sync3 u_sync (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .din(sync_in[gi]),
            .dout(sync_out[gi])
         ); // RL22
      end
   endgenerate
   assign {sup_ok, ph_low, lg_low, oc_raw, fb_uv, fb_ov, fb_below, dis_low, pwm_s} = sync_out;

   // switching cycle tick
   logic [8:0] div_cnt;
   wire cyc_tick = (div_cnt == 9'(buck_seq_pkg::sw_div - 1)); // RL2
   wire pwm_window = (div_cnt < 9'(buck_seq_pkg::sw_div * 4 / 5)); // max duty limit

   // state
   buck_seq_pkg::seq_state_t st;
   buck_seq_pkg::seq_state_t next_st;
   logic [11:0] ss_cnt;
   logic [12:0] off_cnt;
   logic [12:0] off_load;
   logic [11:0] prog_cnt;
   logic prog_done;
   logic hs_started;
   logic oc_prev;
   logic oc_this;
   logic [31:0] ctrl;
   logic [15:0] oc_trips;
   logic wd_pulse;
   logic drv_hi;
   logic drv_lo;

   wire soft_dis = ctrl[buck_seq_pkg::ctrl_soft_dis_bit];
   wire use_fixed = ctrl[buck_seq_pkg::ctrl_fixed_oc_bit];
   wire ss_done = (ss_cnt == 12'(ss_len));
   wire [11:0] ss_left = 12'(ss_len) - ss_cnt;
   wire oc_now = oc_this || (drv_lo && oc_raw); // RL15
   wire oc_trip = cyc_tick && oc_now && oc_prev; // RL16
   wire uv_trip = (st == buck_seq_pkg::st_run) && fb_uv; // RL19
   wire disabled_req = dis_low || soft_dis; // RL12
   wire off_done = (off_cnt == 13'h0000);
   wire ov_active = prog_done && fb_ov; // RL20
   wire [11:0] prog_time = 12'(32'(ocset_len) + 32'(ocset_sample) *
      32'(buck_seq_pkg::ocset_span_cycles) / 32'h0000_00ff);
   wire switching = (st == buck_seq_pkg::st_soft) || (st == buck_seq_pkg::st_run);
   // loop only switches once the ramp has passed the pre-biased output
   wire loop_on = switching && fb_below && pwm_s && pwm_window; // RL6
   // low side held off during ramp until high side has switched, released at ramp end
   wire ls_allow = (st == buck_seq_pkg::st_run) || hs_started; // RL5 RL7
   // off time after soft-start trip is 2048 plus residual ramp time, residual capped at 2048
   always_comb begin
      off_load = 13'(off_len);
      if (st == buck_seq_pkg::st_soft) begin
         off_load = 13'(off_len) + ((ss_left > 12'(off_len)) ? 13'(off_len) : {1'b0, ss_left}); // RL3
      end
   end

   always_comb begin
      next_st = st;
      unique case (st)
         buck_seq_pkg::st_lockout: if (sup_ok) next_st = buck_seq_pkg::st_ocset;
         buck_seq_pkg::st_ocset: if (prog_done) next_st = buck_seq_pkg::st_soft;
         buck_seq_pkg::st_soft: begin
            if (oc_trip) next_st = buck_seq_pkg::st_off; // RL3
            else if (ss_done) next_st = buck_seq_pkg::st_run;
         end
         buck_seq_pkg::st_run: if (oc_trip || uv_trip) next_st = buck_seq_pkg::st_off; // RL16 RL19
         buck_seq_pkg::st_off: if (off_done) next_st = buck_seq_pkg::st_soft; // RL17
         buck_seq_pkg::st_disabled: if (!disabled_req) next_st = buck_seq_pkg::st_soft; // RL13
      endcase
      if (!sup_ok) next_st = buck_seq_pkg::st_lockout; // RL4
      else if (prog_done && disabled_req && st != buck_seq_pkg::st_ocset)
         next_st = buck_seq_pkg::st_disabled;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         div_cnt <= 9'h000;
         st <= buck_seq_pkg::st_lockout;
      end else begin
         div_cnt <= cyc_tick ? 9'h000 : div_cnt + 9'h001;
         st <= next_st;
      end
   end

   // ramp counter and reference code
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ss_cnt <= 12'h000;
         ref_code <= 12'h000;
      end else begin
         if (st != buck_seq_pkg::st_soft && next_st == buck_seq_pkg::st_soft) begin
            ss_cnt <= 12'h000; // RL13
         end else if (st == buck_seq_pkg::st_soft && cyc_tick && !ss_done) begin
            ss_cnt <= ss_cnt + 12'h001; // RL23
         end
         ref_code <= (st == buck_seq_pkg::st_run) ? buck_seq_pkg::ref_full :
            (st == buck_seq_pkg::st_soft) ?
            12'(({12'h000, ss_cnt} * 24'(buck_seq_pkg::ref_full)) / 24'(ss_len)) : 12'h000; // RL1
      end
   end

   // threshold programming and off timer
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         prog_cnt <= 12'h000;
         prog_done <= 1'b0;
         oc_threshold <= 8'h00;
         off_cnt <= 13'h0000;
      end else begin
         if (st == buck_seq_pkg::st_ocset && cyc_tick && !prog_done) begin
            prog_cnt <= prog_cnt + 12'h001; // RL21
            if (prog_cnt == prog_time) begin
               prog_done <= 1'b1;
               oc_threshold <= use_fixed ? buck_seq_pkg::oc_fixed_code : ocset_sample; // RL18
            end
         end
         if (next_st == buck_seq_pkg::st_off && st != buck_seq_pkg::st_off) begin
            off_cnt <= off_load;
         end else if (st == buck_seq_pkg::st_off && cyc_tick && !off_done) begin
            off_cnt <= off_cnt - 13'h0001;
         end
      end
   end

   // overcurrent events per cycle, startup inhibit release
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         oc_this <= 1'b0;
         oc_prev <= 1'b0;
         hs_started <= 1'b0;
         oc_trips <= 16'h0000;
      end else begin
         if (cyc_tick) begin
            oc_prev <= oc_now;
            oc_this <= 1'b0;
         end else if (drv_lo && oc_raw) begin
            oc_this <= 1'b1; // RL15
         end
         if (!switching) hs_started <= 1'b0;
         else if (drv_hi) hs_started <= 1'b1;
         if (oc_trip && switching) oc_trips <= oc_trips + 16'h0001;
      end
   end

   wire all_off = !switching && !ov_active; // RL12 RL16
   gate_driver_phase u_drv (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .pwm_on(loop_on && !ov_active),
      .low_allowed(ls_allow),
      .force_low(ov_active), // RL20 RL8
      .all_off(all_off),
      .phase_low(ph_low),
      .low_gate_low(lg_low),
      .high_en(drv_hi),
      .low_en(drv_lo),
      .watchdog_fire(wd_pulse)
   );

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         high_side_switch <= 1'b0;
         low_side_switch <= 1'b0;
         disable_source_on <= 1'b0;
         ocset_sink_on <= 1'b0;
      end else begin
         high_side_switch <= drv_hi;
         low_side_switch <= drv_lo;
         disable_source_on <= (st == buck_seq_pkg::st_disabled); // RL12 RL14
         ocset_sink_on <= (st == buck_seq_pkg::st_ocset);
      end
   end

   // apb slave, zero wait states
   wire apb_acc = psel && penable;
   wire apb_wr = apb_acc && pwrite && (paddr == buck_seq_pkg::ctrl_addr);
   wire [31:0] status_word = {24'h0, wd_pulse, fb_ov, fb_uv, hs_started, prog_done, 3'(st)};
   wire hit = (paddr == buck_seq_pkg::ctrl_addr) || (paddr == buck_seq_pkg::status_addr) ||
      (paddr == buck_seq_pkg::ramp_addr) || (paddr == buck_seq_pkg::ocset_addr) ||
      (paddr == buck_seq_pkg::count_addr);
   wire [31:0] rd_mux = (paddr == buck_seq_pkg::ctrl_addr) ? ctrl :
      (paddr == buck_seq_pkg::status_addr) ? status_word :
      (paddr == buck_seq_pkg::ramp_addr) ? {20'h0, ref_code} :
      (paddr == buck_seq_pkg::ocset_addr) ? {24'h0, oc_threshold} :
      (paddr == buck_seq_pkg::count_addr) ? {16'h0, oc_trips} : buck_seq_pkg::bad_addr_data;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl <= buck_seq_pkg::ctrl_reset;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         if (apb_wr && pready) ctrl <= {30'h0, pwdata[1:0]};
         pready <= psel && !pready;
         pslverr <= psel && !pready && !hit;
         prdata <= (psel && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   chk_off_no_drive: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL16
      (st == buck_seq_pkg::st_off) && !ov_active |=> ##1 !high_side_switch && !low_side_switch)
      else $error("switch on during off time");
   chk_soft_needs_prog: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL4
      $rose(st == buck_seq_pkg::st_soft) |-> prog_done && $past(sup_ok))
      else $error("soft-start without programming");
   chk_inhibit_low: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL5
      drv_lo && !$past(ov_active) |-> $past(ls_allow))
      else $error("low side during inhibit");
   chk_ov_forces_low: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL20
      ov_active [*3] |-> low_side_switch && !high_side_switch)
      else $error("overvoltage not forcing low side");
   chk_disable_off: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL12
      st == buck_seq_pkg::st_disabled |=> disable_source_on)
      else $error("disable source not on");
   chk_ref_zero_start: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL1
      $rose(st == buck_seq_pkg::st_soft) |=> ref_code == 12'h000)
      else $error("ramp did not restart at zero");
   chk_off_load: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL3
      $rose(st == buck_seq_pkg::st_off) |-> off_cnt >= 13'(off_len))
      else $error("off time shorter than 2048");
   chk_oc_two: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL16
      oc_trip && switching && sup_ok && !disabled_req |=> st == buck_seq_pkg::st_off)
      else $error("trip did not stop switching");
   cov_soft_run: cover property (@(posedge clk_sys) $rose(st == buck_seq_pkg::st_run));
   cov_hiccup: cover property (@(posedge clk_sys) $rose(st == buck_seq_pkg::st_off));
   cov_disable: cover property (@(posedge clk_sys) $rose(st == buck_seq_pkg::st_disabled));
endmodule : buck_startup_protection_sequencer

// *** buck_power_stage_model.sv ***
// buck_power_stage_model: behavioural power switches, gate sense and switch node
// assumes switch commands change on clk_sys edges; every sense level settles in two clocks
`timescale 1ns/1ps
module buck_power_stage_model (
   // clock
   input wire logic clk_sys,
   // switch commands
   input wire logic high_side_switch,
   input wire logic low_side_switch,
   // fault injection
   input wire logic neg_current,
   input wire logic overload,
   // sense levels
   output logic phase_below_th,
   output logic low_gate_below_th,
   output logic oc_drop_over_th
);
   logic [1:0] hs_d = 2'b00;
   logic [1:0] ls_d = 2'b00;
   // settling delay so the dead-time logic has to wait for the sense levels
   always @(posedge clk_sys) begin
      hs_d <= {hs_d[0], high_side_switch};
      ls_d <= {ls_d[0], low_side_switch};
   end
   // negative current keeps the node up until the low side pulls it down
   assign phase_below_th = neg_current ? ls_d[1] : !hs_d[1];
   assign low_gate_below_th = !ls_d[1];
   assign oc_drop_over_th = overload && ls_d[1];
endmodule : buck_power_stage_model

// *** buck_startup_protection_sequencer_tb.sv ***
// buck_startup_protection_sequencer_tb: self-checking bench for startup, protection, dead time
// assumes the power stage model beside it; state is followed through the status register
`timescale 1ns/1ps
module buck_startup_protection_sequencer_tb;
   localparam int ss_len = 20;
   localparam int off_len = 16;
   localparam int ocset_len = 10;
   localparam int sw = buck_seq_pkg::sw_div;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic supply_lockout_ok = 1'b0;
   logic phase_below_th;
   logic low_gate_below_th;
   logic oc_drop_over_th;
   logic feedback_input_under = 1'b0;
   logic feedback_input_over = 1'b0;
   logic feedback_input_below_ref = 1'b0;
   logic error_amp_output_disable_pin_low = 1'b0;
   logic pwm_cmp = 1'b0;
   logic [7:0] ocset_sample = 8'h04;
   logic high_side_switch;
   logic low_side_switch;
   logic disable_source_on;
   logic ocset_sink_on;
   logic [11:0] ref_code;
   logic [7:0] oc_threshold;
   logic neg_current = 1'b0;
   logic overload = 1'b0;
   logic pwm_en = 1'b0;
   logic hs_q = 1'b0;
   logic ls_q = 1'b0;
   int pwm_ph = 0;
   int cyc = 0;
   int took = 0;
   int hs_rises = 0;
   int ls_rises = 0;
   int err_count = 0;
   int checks_done = 0;

   buck_startup_protection_sequencer #(.ss_len(ss_len), .off_len(off_len),
      .ocset_len(ocset_len)) buck_startup_protection_sequencer_i (.clk_sys, .sys_rst, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .supply_lockout_ok,
      .phase_below_th, .low_gate_below_th, .oc_drop_over_th, .feedback_input_under,
      .feedback_input_over, .feedback_input_below_ref, .error_amp_output_disable_pin_low,
      .pwm_cmp, .ocset_sample, .high_side_switch, .low_side_switch, .disable_source_on,
      .ocset_sink_on, .ref_code, .oc_threshold);
   buck_power_stage_model buck_power_stage_model_i (.clk_sys, .high_side_switch,
      .low_side_switch, .neg_current, .overload, .phase_below_th, .low_gate_below_th,
      .oc_drop_over_th);

   initial forever #5 clk_sys = ~clk_sys;

   task automatic close_out();
      if (err_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out

   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check_val

   task automatic check_range(input string what, input int lo, input int hi, input int got);
      checks_done++;
      if (got < lo || got > hi) begin
         err_count++;
         $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : check_range

   // setup then access; everything held until pready is sampled high
   task automatic apb_rw(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd, output logic er);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb_rw

   // polls the state field; took holds the cycles spent waiting
   task automatic wait_state(input logic [2:0] st, input int lim);
      logic [31:0] d;
      logic e;
      int t0;
      t0 = cyc;
      d = 32'hffff_ffff;
      while (d[2:0] !== st && cyc - t0 < lim) apb_rw(1'b0, buck_seq_pkg::status_addr, 32'h0, d, e);
      check_val("state", 32'(st), 32'(d[2:0]));
      took = cyc - t0;
   endtask : wait_state

   task automatic t_reset();
      logic [31:0] d;
      logic e;
      check_val("outputs after reset", 32'h0, 32'({high_side_switch, low_side_switch,
         disable_source_on, ocset_sink_on, ref_code, oc_threshold}));
      apb_rw(1'b0, buck_seq_pkg::ctrl_addr, 32'h0, d, e);
      check_val("ctrl reset", buck_seq_pkg::ctrl_reset, d);
      apb_rw(1'b0, 8'h14, 32'h0, d, e);
      check_val("unmapped data", buck_seq_pkg::bad_addr_data, d);
      check_val("unmapped error", 32'h1, 32'(e));
      repeat (10) @(posedge clk_sys);
      wait_state(buck_seq_pkg::st_lockout, 4);
   endtask : t_reset

   // output pre-biased above target: no switching until the ramp ends
   task automatic t_startup();
      int ts;
      supply_lockout_ok <= 1'b1;
      wait_state(buck_seq_pkg::st_ocset, 20);
      check_val("programming sink", 32'h1, 32'(ocset_sink_on));
      wait_state(buck_seq_pkg::st_soft, 30 * sw);
      check_range("programming time", (ocset_len + 3) * sw, (ocset_len + 6) * sw, took);
      ts = cyc;
      check_val("stored threshold", 32'h4, 32'(oc_threshold));
      ls_rises = 0;
      hs_rises = 0;
      repeat ((ss_len - 2) * sw) @(posedge clk_sys);
      check_val("low side in soft-start", 32'h0, 32'(ls_rises));
      check_val("high side in soft-start", 32'h0, 32'(hs_rises));
      wait_state(buck_seq_pkg::st_run, 4 * sw);
      check_range("soft-start time", (ss_len - 1) * sw, (ss_len + 1) * sw, cyc - ts);
      check_val("full reference", 32'(buck_seq_pkg::ref_full), 32'(ref_code));
      repeat (8) @(posedge clk_sys);
      check_val("discharge low side", 32'h1, 32'(low_side_switch));
   endtask : t_startup

   task automatic t_switch();
      pwm_en <= 1'b1;
      repeat (2 * sw) @(posedge clk_sys);
      hs_rises = 0;
      repeat (10 * sw) @(posedge clk_sys);
      check_range("switching cycles", 9, 11, hs_rises);
   endtask : t_switch

   task automatic t_watchdog();
      neg_current <= 1'b1;
      repeat (sw) @(posedge clk_sys);
      ls_rises = 0;
      repeat (4 * sw) @(posedge clk_sys);
      check_range("watchdog turn-ons", 3, 5, ls_rises);
      neg_current <= 1'b0;
   endtask : t_watchdog

   task automatic t_overvoltage();
      feedback_input_over <= 1'b1;
      repeat (8) @(posedge clk_sys);
      hs_rises = 0;
      repeat (sw) @(posedge clk_sys);
      check_val("overvoltage drive", 32'h1, 32'({high_side_switch, low_side_switch}));
      check_val("high side held off", 32'h0, 32'(hs_rises));
      feedback_input_over <= 1'b0;
   endtask : t_overvoltage

   // persistent overload: trip in run, restart, trip again inside soft-start
   task automatic t_overcurrent();
      logic [31:0] d;
      logic e;
      overload <= 1'b1;
      wait_state(buck_seq_pkg::st_off, 4 * sw);
      repeat (2) @(posedge clk_sys);
      check_val("both off", 32'h0, 32'({high_side_switch, low_side_switch}));
      wait_state(buck_seq_pkg::st_soft, 3 * off_len * sw);
      check_range("off time", (off_len - 1) * sw, (off_len + 1) * sw, took);
      wait_state(buck_seq_pkg::st_off, ss_len * sw);
      apb_rw(1'b0, buck_seq_pkg::count_addr, 32'h0, d, e);
      check_val("trip count", 32'h2, d);
      overload <= 1'b0;
      wait_state(buck_seq_pkg::st_soft, 3 * off_len * sw);
      check_range("off time with residual", off_len * sw, (2 * off_len + 1) * sw, took);
      wait_state(buck_seq_pkg::st_run, (ss_len + 1) * sw);
   endtask : t_overcurrent

   task automatic t_undervoltage();
      feedback_input_under <= 1'b1;
      wait_state(buck_seq_pkg::st_off, 2 * sw);
      feedback_input_under <= 1'b0;
      wait_state(buck_seq_pkg::st_soft, 3 * off_len * sw);
      check_range("undervoltage off time", (off_len - 1) * sw, (off_len + 1) * sw, took);
      wait_state(buck_seq_pkg::st_run, (ss_len + 1) * sw);
   endtask : t_undervoltage

   task automatic t_disable();
      logic [31:0] d;
      logic e;
      error_amp_output_disable_pin_low <= 1'b1;
      repeat (3 * sw) @(posedge clk_sys);
      check_val("disabled drive", 32'h1, 32'({high_side_switch, low_side_switch,
         disable_source_on}));
      wait_state(buck_seq_pkg::st_disabled, 4);
      error_amp_output_disable_pin_low <= 1'b0;
      wait_state(buck_seq_pkg::st_soft, 20);
      check_val("reference restarted", 32'h0, 32'(ref_code[11:10]));
      apb_rw(1'b1, buck_seq_pkg::ctrl_addr, 32'h1, d, e);
      wait_state(buck_seq_pkg::st_disabled, 8);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      apb_rw(1'b1, buck_seq_pkg::ctrl_addr, 32'h2, d, e);
      wait_state(buck_seq_pkg::st_soft, 30 * sw);
      apb_rw(1'b0, buck_seq_pkg::ocset_addr, 32'h0, d, e);
      check_val("fixed threshold", 32'(buck_seq_pkg::oc_fixed_code), d);
   endtask : t_disable

   // loop comparator stand-in: 40 percent duty at the switching rate
   always @(posedge clk_sys) begin
      pwm_ph <= (pwm_ph == sw - 1) ? 0 : pwm_ph + 1;
      pwm_cmp <= pwm_en && pwm_ph < sw * 2 / 5;
      feedback_input_below_ref <= pwm_en;
   end

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      hs_q <= high_side_switch;
      ls_q <= low_side_switch;
      if (high_side_switch === 1'b1 && low_side_switch === 1'b1) check_val("overlap", 0, 1);
      if (high_side_switch === 1'b1 && !hs_q) begin
         hs_rises++;
         check_val("low gate sensed off", 32'h1, 32'(low_gate_below_th));
      end
      if (low_side_switch === 1'b1 && !ls_q) begin
         ls_rises++;
         if (!neg_current && !feedback_input_over) check_val("node low", 1, 32'(phase_below_th));
      end
   end

   initial begin
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      t_reset();
      t_startup();
      t_switch();
      t_watchdog();
      t_overvoltage();
      t_overcurrent();
      t_undervoltage();
      t_disable();
      close_out();
   end

   initial begin
      repeat (95000) @(posedge clk_sys);
      err_count++;
      close_out();
   end
endmodule : buck_startup_protection_sequencer_tb
